// ==== design/abbc_pkg.sv ====
// Constants shared by the bus buffer controller
package abbc_pkg;
    localparam int        ADDR_CODE_W   = 5;
    localparam logic [1:0] ADDR_MSB_FIXED = 2'h3;
    localparam int        CMD_COUNT     = 4;
    // Configuration register indices
    localparam logic [1:0] REG_GP_MODE  = 2'h0;
    localparam logic [1:0] REG_GP_OUT   = 2'h1;
    localparam logic [1:0] REG_CTRL     = 2'h2;
    localparam logic [1:0] REG_STATUS   = 2'h3;
    // Pin mode encoding, two bits per pin
    localparam logic [1:0] GP_MODE_IN   = 2'h0;
    localparam logic [1:0] GP_MODE_OD   = 2'h1;
    localparam logic [1:0] GP_MODE_PP   = 2'h2;
    // Reset values
    localparam logic [7:0] GP_MODE_RST  = 8'h05;
    localparam logic [7:0] GP_OUT_RST   = 8'h03;
    localparam logic [7:0] CTRL_RST     = 8'h00;
    // Control bit positions and bit counter limits
    localparam int        CTRL_CONNECT  = 0;
    localparam int        CTRL_ACCEL    = 1;
    localparam logic [2:0] BIT_LAST     = 3'h7;
    localparam logic [2:0] BIT_FIRST    = 3'h0;
endpackage : abbc_pkg

// ==== design/abbc_gp_pin.sv ====
// One general purpose pin driver
module abbc_gp_pin
    import abbc_pkg::*;
(
    // Configuration
    input  wire logic [1:0] mode,
    input  wire logic       level,
    // Pin
    input  wire logic       pin_in,
    output logic            pin_out,
    output logic            pin_oe_n,
    // Readback
    output logic            pin_state
);
    always_comb begin
        pin_out  = level;
        pin_oe_n = 1'b1;
        unique case (mode)
            GP_MODE_OD: pin_oe_n = level;
            GP_MODE_PP: pin_oe_n = 1'b0;
            default:    pin_oe_n = 1'b1;
        endcase
    end
    assign pin_state = pin_in;
endmodule : abbc_gp_pin

// ==== design/abbc_top.sv ====
// Digital controller of the addressable two-wire bus buffer
module abbc_top
    import abbc_pkg::*;
#(
    parameter bit DUAL_SUPPLY = 1'b0
)(
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   reset_n,
    // Supervision
    input  wire logic                   connect_sense,
    input  wire logic                   undervoltage_lockout,
    input  wire logic                   card_undervoltage_lockout,
    input  wire logic [ADDR_CODE_W-1:0] address_code,
    // Backplane bus
    input  wire logic                   backplane_clock_in,
    input  wire logic                   backplane_data_in,
    output logic                        backplane_data_out,
    output logic                        backplane_data_oe_n,
    output logic                        backplane_clock_out,
    output logic                        backplane_clock_oe_n,
    // Precharge
    output logic                        precharge_backplane,
    output logic                        precharge_card,
    // Analog controls
    output logic                        connect_enable,
    output logic                        accel_enable,
    // General purpose pins
    input  wire logic                   gp_pin_one_in,
    output logic                        gp_pin_one_out,
    output logic                        gp_pin_one_oe_n,
    input  wire logic                   gp_pin_two_in,
    output logic                        gp_pin_two_out,
    output logic                        gp_pin_two_oe_n
);
    typedef enum logic [2:0] {
        ABBC_IDLE = 3'b000,
        ABBC_ADDR = 3'b001,
        ABBC_ACK  = 3'b010,
        ABBC_WR   = 3'b011,
        ABBC_RD   = 3'b100,
        ABBC_RACK = 3'b101,
        ABBC_SKIP = 3'b110,
        ABBC_HOLD = 3'b111
    } abbc_state_t;

    logic        rst_s1_reg, rst_s2_reg;
    logic        attach_s1_reg, attach_rst_n;
    logic        scl_d_reg, sda_d_reg;
    logic        active;
    logic        start_ev, stop_ev, scl_rise, scl_fall;
    abbc_state_t state_reg;
    logic [2:0]  bit_reg;
    logic [7:0]  shift_reg;
    logic        rw_reg, first_reg, ack_drive_reg;
    logic [1:0]  ptr_reg;
    logic [7:0]  gp_mode_reg, gp_out_reg, ctrl_reg;
    logic [7:0]  rd_byte;
    logic [6:0]  own_addr;
    logic        gp1_state, gp2_state;

    // Global reset release
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_s2_reg <= rst_s1_reg;
        end
    end

    // Connect low resets at once; release passes through two flops
    wire attach_async_n = rst_s2_reg & connect_sense;
    always_ff @(posedge clock or negedge attach_async_n) begin
        if (!attach_async_n) begin
            attach_s1_reg <= 1'b0;
            attach_rst_n  <= 1'b0;
        end else begin
            attach_s1_reg <= 1'b1;
            attach_rst_n  <= attach_s1_reg;
        end
    end

    assign active   = attach_rst_n & ~undervoltage_lockout;
    assign own_addr = {ADDR_MSB_FIXED, address_code};

    // Lockout freezes the pin samples so bus activity is not seen
    always_ff @(posedge clock or negedge rst_s2_reg) begin
        if (!rst_s2_reg) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else if (!undervoltage_lockout) begin
            scl_d_reg <= backplane_clock_in;
            sda_d_reg <= backplane_data_in;
        end
    end

    wire scl_now = undervoltage_lockout ? scl_d_reg : backplane_clock_in;
    wire sda_now = undervoltage_lockout ? sda_d_reg : backplane_data_in;
    assign start_ev = active & scl_now & scl_d_reg & sda_d_reg & ~sda_now;
    assign stop_ev  = active & scl_now & scl_d_reg & ~sda_d_reg & sda_now;
    assign scl_rise = active & scl_now & ~scl_d_reg;
    assign scl_fall = active & ~scl_now & scl_d_reg;

    // Slave state machine
    always_ff @(posedge clock or negedge attach_rst_n) begin
        if (!attach_rst_n) begin
            state_reg <= ABBC_IDLE;
            bit_reg   <= BIT_FIRST;
            shift_reg <= 8'h00;
            rw_reg    <= 1'b0;
            first_reg <= 1'b0;
            ptr_reg   <= REG_GP_MODE;
        end else if (!active || stop_ev) begin
            state_reg <= ABBC_IDLE;
        end else if (start_ev) begin
            state_reg <= ABBC_HOLD;
            bit_reg   <= BIT_FIRST;
        end else begin
            unique case (state_reg)
                ABBC_IDLE, ABBC_SKIP: begin
                end
                // The clock fall that closes a start is not a data bit
                ABBC_HOLD: begin
                    if (scl_fall) begin
                        state_reg <= ABBC_ADDR;
                    end
                end
                ABBC_ADDR, ABBC_WR: begin
                    if (scl_rise) begin
                        shift_reg <= {shift_reg[6:0], sda_now};
                    end
                    if (scl_fall) begin
                        bit_reg <= bit_reg + 3'h1;
                        if (bit_reg == BIT_LAST) begin
                            if (state_reg == ABBC_ADDR) begin
                                if (shift_reg[7:1] == own_addr) begin
                                    rw_reg    <= shift_reg[0];
                                    first_reg <= ~shift_reg[0];
                                    state_reg <= ABBC_ACK;
                                end else begin
                                    state_reg <= ABBC_SKIP;
                                end
                            end else begin
                                if (first_reg) begin
                                    ptr_reg <= shift_reg[1:0];
                                end else begin
                                    ptr_reg <= ptr_reg + 2'h1;
                                end
                                first_reg <= 1'b0;
                                state_reg <= ABBC_ACK;
                            end
                        end
                    end
                end
                ABBC_ACK: begin
                    if (scl_fall) begin
                        bit_reg   <= BIT_FIRST;
                        shift_reg <= rd_byte;
                        state_reg <= rw_reg ? ABBC_RD : ABBC_WR;
                    end
                end
                ABBC_RD: begin
                    if (scl_fall) begin
                        bit_reg   <= bit_reg + 3'h1;
                        shift_reg <= {shift_reg[6:0], 1'b0};
                        if (bit_reg == BIT_LAST) begin
                            state_reg <= ABBC_RACK;
                            ptr_reg   <= ptr_reg + 2'h1;
                        end
                    end
                end
                ABBC_RACK: begin
                    if (scl_rise && sda_now) begin
                        state_reg <= ABBC_SKIP;
                    end else if (scl_fall) begin
                        bit_reg   <= BIT_FIRST;
                        shift_reg <= rd_byte;
                        state_reg <= ABBC_RD;
                    end
                end
            endcase
        end
    end

    // Register write on the byte boundary after the command byte
    wire wr_commit = active & ~stop_ev & ~start_ev & scl_fall & (state_reg == ABBC_WR)
                     & (bit_reg == BIT_LAST) & ~first_reg;
    wire [1:0] wr_ptr = ptr_reg;
    always_ff @(posedge clock or negedge attach_rst_n) begin
        if (!attach_rst_n) begin
            gp_mode_reg <= GP_MODE_RST;
            gp_out_reg  <= GP_OUT_RST;
            ctrl_reg    <= CTRL_RST;
        end else if (wr_commit) begin
            unique case (wr_ptr)
                REG_GP_MODE: gp_mode_reg <= shift_reg;
                REG_GP_OUT:  gp_out_reg  <= shift_reg;
                REG_CTRL:    ctrl_reg    <= shift_reg;
                REG_STATUS:  ctrl_reg    <= ctrl_reg;
            endcase
        end
    end

    always_comb begin
        unique case (ptr_reg)
            REG_GP_MODE: rd_byte = gp_mode_reg;
            REG_GP_OUT:  rd_byte = gp_out_reg;
            REG_CTRL:    rd_byte = ctrl_reg;
            REG_STATUS:  rd_byte = {6'h00, gp2_state, gp1_state};
        endcase
    end

    // Data driver only for acknowledge and read zeros
    // Master acknowledge slots stay undriven: ACK is entered only for our own acknowledge
    always_ff @(posedge clock or negedge attach_rst_n) begin
        if (!attach_rst_n) begin
            ack_drive_reg <= 1'b0;
        end else begin
            ack_drive_reg <= active & ((state_reg == ABBC_ACK)
                             | ((state_reg == ABBC_RD) & ~shift_reg[7]));
        end
    end
    assign backplane_data_out   = 1'b0;
    assign backplane_data_oe_n  = ~(ack_drive_reg & active);
    assign backplane_clock_out  = 1'b0;
    assign backplane_clock_oe_n = 1'b1;

    // Precharge follows the lockout flags
    assign precharge_backplane = undervoltage_lockout;
    assign precharge_card = DUAL_SUPPLY ? card_undervoltage_lockout
                                        : undervoltage_lockout;

    assign connect_enable = ctrl_reg[CTRL_CONNECT];
    assign accel_enable   = ctrl_reg[CTRL_ACCEL];

    abbc_gp_pin u_gp_one (
        .mode      (gp_mode_reg[1:0]),
        .level     (gp_out_reg[0]),
        .pin_in    (gp_pin_one_in),
        .pin_out   (gp_pin_one_out),
        .pin_oe_n  (gp_pin_one_oe_n),
        .pin_state (gp1_state)
    );
    abbc_gp_pin u_gp_two (
        .mode      (gp_mode_reg[3:2]),
        .level     (gp_out_reg[1]),
        .pin_in    (gp_pin_two_in),
        .pin_out   (gp_pin_two_out),
        .pin_oe_n  (gp_pin_two_oe_n),
        .pin_state (gp2_state)
    );

    chk_no_clock_stretch: assert property (@(posedge clock) disable iff (!rst_s2_reg)
        backplane_clock_oe_n) else $error("Clock line driven");
    chk_quiet_detached: assert property (@(posedge clock) disable iff (!rst_s2_reg)
        !connect_sense |=> backplane_data_oe_n) else $error("Drive while disconnected");
    chk_defaults_detached: assert property (@(posedge clock) disable iff (!rst_s2_reg)
        !connect_sense |=> gp_mode_reg == GP_MODE_RST && gp_out_reg == GP_OUT_RST && ctrl_reg == CTRL_RST)
        else $error("Not default");
    chk_lockout_quiet: assert property (@(posedge clock) disable iff (!rst_s2_reg)
        undervoltage_lockout |-> backplane_data_oe_n) else $error("Drive in lockout");
    chk_precharge_main: assert property (@(posedge clock) disable iff (!rst_s2_reg)
        precharge_backplane == undervoltage_lockout) else $error("Precharge wrong");
    chk_precharge_card: assert property (@(posedge clock) disable iff (!rst_s2_reg)
        DUAL_SUPPLY || precharge_card == undervoltage_lockout) else $error("Card precharge");
    chk_precharge_dual: assert property (@(posedge clock) disable iff (!rst_s2_reg)
        !DUAL_SUPPLY || precharge_card == card_undervoltage_lockout) else $error("Card precharge dual");
    chk_idle_after_attach: assert property (@(posedge clock) disable iff (!rst_s2_reg)
        $rose(connect_sense) |-> ##1 state_reg == ABBC_IDLE) else $error("Not idle");
    chk_addr_fixed_msb: assert property (@(posedge clock) disable iff (!rst_s2_reg)
        own_addr[6:5] == ADDR_MSB_FIXED) else $error("Address top bits");
    chk_pull_reason: assert property (@(posedge clock) disable iff (!rst_s2_reg)
        !backplane_data_oe_n |-> $past(state_reg) == ABBC_ACK
                                 || ($past(state_reg) == ABBC_RD && !$past(shift_reg[7])))
        else $error("Data pulled outside ack or zero bit");
endmodule : abbc_top

// ==== tb/abbc_bus_master.sv ====
// Two-wire bus master model that drives the controller's backplane bus
module abbc_bus_master #(
    parameter int QUARTER = 10
)(
    // Clock
    input  wire logic clock,
    // Bus lines
    input  wire logic sda_line,
    output logic      scl_drive,
    output logic      sda_drive
);
    timeunit 1ns;
    timeprecision 1ps;

    // Lines released at start, so the pull-ups hold the bus idle
    initial begin
        scl_drive = 1'b1;
        sda_drive = 1'b1;
    end

    task automatic quarter();
        repeat (QUARTER) @(negedge clock);
    endtask : quarter

    // Also serves as repeated start, entered with the clock low
    task automatic start_cond();
        sda_drive = 1'b1;
        quarter();
        scl_drive = 1'b1;
        quarter();
        sda_drive = 1'b0;
        quarter();
        scl_drive = 1'b0;
        quarter();
    endtask : start_cond

    task automatic stop_cond();
        sda_drive = 1'b0;
        quarter();
        scl_drive = 1'b1;
        quarter();
        sda_drive = 1'b1;
        quarter();
    endtask : stop_cond

    // Data changes only while the clock is low; sampled mid-high
    task automatic xfer_bit(input logic b, output logic r);
        sda_drive = b;
        quarter();
        scl_drive = 1'b1;
        quarter();
        r = sda_line;
        quarter();
        scl_drive = 1'b0;
        quarter();
    endtask : xfer_bit

    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(d[i], r);
        end
        xfer_bit(1'b1, r);
        ack = ~r;
    endtask : send_byte

    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, d[i]);
        end
        xfer_bit(last, r);
    endtask : recv_byte
endmodule : abbc_bus_master

// ==== tb/abbc_tb_top.sv ====
// Self-checking testbench of the bus buffer controller
module abbc_tb_top;
    import abbc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock, reset_n, connect_sense, lockout, card_lockout;
    logic [4:0] address_code;
    logic [6:0] own;
    logic sda_drv, scl_drv, sda_wire, scl_wire, one_wire, two_wire;
    logic bp_data_out, bp_data_oe_n, bp_clock_out, bp_clock_oe_n, pre_bp, pre_card, link_en, accel_en;
    logic one_out, one_oe_n, two_out, two_oe_n, ack;
    logic dual_pre_bp, dual_pre_card;
    logic [7:0] rd;
    int miscompares, tests_run, pull_base;
    int pulls = 0;
    int stretches = 0;
    logic [4:0] codes [3] = '{5'h00, 5'h1f, 5'h0a};
    logic [7:0] mode_tab [4] = '{8'h02, 8'h02, 8'h05, 8'h09};
    logic [7:0] lvl_tab [4] = '{8'h00, 8'h01, 8'h02, 8'h01};
    logic [1:0] oe_tab [4] = '{2'h2, 2'h2, 2'h2, 2'h1};

    // Open-drain bus wires: every party can only pull low; pin wires follow their enabled driver
    assign sda_wire = sda_drv & (bp_data_oe_n ? 1'b1 : bp_data_out);
    assign scl_wire = scl_drv & (bp_clock_oe_n ? 1'b1 : bp_clock_out);
    assign one_wire = one_oe_n ? 1'b1 : one_out;
    assign two_wire = two_oe_n ? 1'b1 : two_out;
    assign own = {2'h3, address_code};

    always #10 clock = ~clock;

    always @(posedge clock) begin
        pulls <= pulls + (bp_data_oe_n ? 0 : 1);
        stretches <= stretches + (bp_clock_oe_n ? 0 : 1);
    end

    abbc_bus_master i_abbc_bus_master (.clock(clock), .sda_line(sda_wire), .scl_drive(scl_drv), .sda_drive(sda_drv));

    abbc_top i_abbc_top (
        .clock(clock), .reset_n(reset_n), .connect_sense(connect_sense), .undervoltage_lockout(lockout),
        .card_undervoltage_lockout(card_lockout), .address_code(address_code),
        .backplane_clock_in(scl_wire), .backplane_data_in(sda_wire), .backplane_data_out(bp_data_out),
        .backplane_data_oe_n(bp_data_oe_n), .backplane_clock_out(bp_clock_out),
        .backplane_clock_oe_n(bp_clock_oe_n), .precharge_backplane(pre_bp), .precharge_card(pre_card),
        .connect_enable(link_en), .accel_enable(accel_en), .gp_pin_one_in(one_wire),
        .gp_pin_one_out(one_out), .gp_pin_one_oe_n(one_oe_n), .gp_pin_two_in(two_wire),
        .gp_pin_two_out(two_out), .gp_pin_two_oe_n(two_oe_n));

    // Dual-supply variant shares all inputs but the pin inputs; only its precharge outputs are watched
    if (1'b1) begin : g_dual
        abbc_top #(.DUAL_SUPPLY(1'b1)) i_abbc_top (
            .clock(clock), .reset_n(reset_n), .connect_sense(connect_sense), .undervoltage_lockout(lockout),
            .card_undervoltage_lockout(card_lockout), .address_code(address_code),
            .backplane_clock_in(scl_wire), .backplane_data_in(sda_wire), .backplane_data_out(),
            .backplane_data_oe_n(), .backplane_clock_out(), .backplane_clock_oe_n(),
            .precharge_backplane(dual_pre_bp), .precharge_card(dual_pre_card), .connect_enable(),
            .accel_enable(), .gp_pin_one_in(1'b1), .gp_pin_one_out(), .gp_pin_one_oe_n(),
            .gp_pin_two_in(1'b1), .gp_pin_two_out(), .gp_pin_two_oe_n());
    end

    task automatic check_bit(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_bit

    task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check_byte

    task automatic probe(input logic [6:0] addr, output logic a);
        i_abbc_bus_master.start_cond();
        i_abbc_bus_master.send_byte({addr, 1'b0}, a);
        i_abbc_bus_master.stop_cond();
    endtask : probe

    task automatic reg_write(input logic [1:0] idx, input logic [7:0] data, output logic a);
        logic a1, a2;
        i_abbc_bus_master.start_cond();
        i_abbc_bus_master.send_byte({own, 1'b0}, a);
        i_abbc_bus_master.send_byte({6'h00, idx}, a1);
        i_abbc_bus_master.send_byte(data, a2);
        i_abbc_bus_master.stop_cond();
        a = a & a1 & a2;
    endtask : reg_write

    task automatic reg_read(input logic [1:0] idx, output logic [7:0] data);
        logic a;
        i_abbc_bus_master.start_cond();
        i_abbc_bus_master.send_byte({own, 1'b0}, a);
        i_abbc_bus_master.send_byte({6'h00, idx}, a);
        i_abbc_bus_master.start_cond();
        i_abbc_bus_master.send_byte({own, 1'b1}, a);
        i_abbc_bus_master.recv_byte(1'b1, data);
        i_abbc_bus_master.stop_cond();
    endtask : reg_read

    task automatic test_done();
        if (miscompares == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : test_done

    // Roughly 20190 cycles of traffic expected; a hang ends the run
    initial begin
        repeat (60000) @(posedge clock);
        miscompares++;
        test_done();
    end

    initial begin
        {clock, reset_n, lockout, card_lockout, miscompares, tests_run} = '0;
        connect_sense = 1'b1;
        address_code = 5'h15;
        repeat (3) @(negedge clock);
        reset_n = 1'b1;
        repeat (4) @(negedge clock);
        check_bit(link_en, 1'b0);
        check_bit(accel_en, 1'b0);
        check_bit(one_oe_n, 1'b1);
        check_bit(two_oe_n, 1'b1);
        for (int k = 0; k < 3; k++) begin
            address_code = codes[k];
            probe({2'h3, codes[k]}, ack);
            check_bit(ack, 1'b1);
            probe({2'h2, codes[k]}, ack);
            check_bit(ack, 1'b0);
            probe({2'h3, codes[k] ^ 5'h01}, ack);
            check_bit(ack, 1'b0);
        end
        address_code = 5'h15;
        reg_write(REG_CTRL, 8'h03, ack);
        @(negedge clock);
        check_bit(ack, 1'b1);
        check_bit(link_en, 1'b1);
        check_bit(accel_en, 1'b1);
        reg_read(REG_CTRL, rd);
        check_byte(rd, 8'h03);
        for (int k = 0; k < 4; k++) begin
            reg_write(REG_GP_MODE, mode_tab[k], ack);
            reg_write(REG_GP_OUT, lvl_tab[k], ack);
            repeat (2) @(negedge clock);
            check_bit(one_oe_n, oe_tab[k][0]);
            check_bit(two_oe_n, oe_tab[k][1]);
            if (!oe_tab[k][0]) check_bit(one_out, lvl_tab[k][0]);
            if (!oe_tab[k][1]) check_bit(two_out, lvl_tab[k][1]);
        end
        // Pin one released to its pull-up, pin two driven low
        reg_read(REG_STATUS, rd);
        check_byte(rd, 8'h01);
        // Pin two is driven now, so the default must visibly release it
        connect_sense = 1'b0;
        @(negedge clock);
        check_bit(link_en, 1'b0);
        check_bit(two_oe_n, 1'b1);
        pull_base = pulls;
        probe(own, ack);
        check_bit(ack, 1'b0);
        check_bit(pulls == pull_base, 1'b1);
        connect_sense = 1'b1;
        repeat (4) @(negedge clock);
        reg_read(REG_GP_MODE, rd);
        check_byte(rd, 8'h05);
        check_bit(link_en, 1'b0);
        lockout = 1'b1;
        repeat (2) @(negedge clock);
        check_bit(pre_bp, 1'b1);
        check_bit(pre_card, 1'b1);
        check_bit(dual_pre_bp, 1'b1);
        check_bit(dual_pre_card, 1'b0);
        pull_base = pulls;
        probe(own, ack);
        check_bit(ack, 1'b0);
        check_bit(pulls == pull_base, 1'b1);
        lockout = 1'b0;
        card_lockout = 1'b1;
        repeat (2) @(negedge clock);
        check_bit(pre_bp, 1'b0);
        check_bit(pre_card, 1'b0);
        check_bit(dual_pre_bp, 1'b0);
        check_bit(dual_pre_card, 1'b1);
        card_lockout = 1'b0;
        repeat (4) @(negedge clock);
        probe(own, ack);
        check_bit(ack, 1'b1);
        check_bit(stretches == 0, 1'b1);
        test_done();
    end
endmodule : abbc_tb_top
